// >>> rtl/dftc_core.sv
/*
 * Per-channel overtemperature limits, fan on/off hysteresis and the
 * short/long cycle scheduler that moves each channel's fan start
 * temperature, behind a classic Wishbone register slave.
 * Assumes temp_i and mon_tick_i come from the measurement logic on clk;
 * mon_tick_i pulses one cycle when a monitoring cycle has completed.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module dftc_core
    import dftc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mon_tick_i,
    input wire logic [NCH-1:0][7:0] temp_i,
    output dftc_drive_e fan_drive_1,
    output dftc_drive_e fan_drive_2,
    output dftc_drive_e fan_drive_3,
    output logic overtemp_pin_n,
    output logic [NCH-1:0][7:0] fan_start_temp
);

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [NCH-1:0][7:0] op_q, op_d, low_q, low_d, high_q, high_d;
    logic [NCH-1:0][7:0] otl_q, otl_d, fan_start_temp_q, fan_start_temp_d;
    logic [7:0] hys_a_q, hys_a_d, cal1_q, cal1_d, cal2_q, cal2_d;
    logic [7:0] acou_q, acou_d;
    logic [3:0] hys_b_q, hys_b_d;
    logic [NCH-1:0] lowf_q, lowf_d, highf_q, highf_d;
    logic ack_q, ack_d;
    logic [7:0] dat_q, dat_d;
    logic wb_hit, wr_en;
    logic [6:0] idx;
    logic [7:0] wbyte;
    logic [NCH-1:0][7:0] fan_start_temp_hw;
    logic [NCH-1:0] lowf_set, highf_set;
    logic [NCH-1:0] over_q, over_d;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en = wb_hit & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[ADR_W-1:2];
    assign wbyte = wb_dat_i[7:0];

    always_comb begin
        op_d = op_q;
        low_d = low_q;
        high_d = high_q;
        otl_d = otl_q;
        hys_a_d = hys_a_q;
        hys_b_d = hys_b_q;
        cal1_d = cal1_q;
        cal2_d = cal2_q;
        acou_d = acou_q;
        // Hardware moves the start temperature; a software write wins
        fan_start_temp_d = fan_start_temp_hw;
        // Set wins over a write-one clear in the same cycle
        lowf_d = lowf_q | lowf_set;
        highf_d = highf_q | highf_set;
        ack_d = wb_hit;
        dat_d = 8'h00;
        if (wr_en) begin
            unique case (idx)
                IDX_OP_R1: op_d[0] = wbyte;
                IDX_OP_LOC: op_d[1] = wbyte;
                IDX_OP_R2: op_d[2] = wbyte;
                IDX_CAL1: cal1_d = wbyte;
                IDX_CAL2: cal2_d = wbyte;
                IDX_LOW_R1: low_d[0] = wbyte;
                IDX_HIGH_R1: high_d[0] = wbyte;
                IDX_LOW_LOC: low_d[1] = wbyte;
                IDX_HIGH_LOC: high_d[1] = wbyte;
                IDX_LOW_R2: low_d[2] = wbyte;
                IDX_HIGH_R2: high_d[2] = wbyte;
                IDX_ACOU: acou_d = wbyte;
                IDX_OTL_R1: otl_d[0] = wbyte;
                IDX_OTL_LOC: otl_d[1] = wbyte;
                IDX_OTL_R2: otl_d[2] = wbyte;
                IDX_HYS_A: hys_a_d = wbyte;
                IDX_HYS_B: hys_b_d = wbyte[7:4];
                IDX_FAN_START_TEMP_R1: fan_start_temp_d[0] = wbyte;
                IDX_FAN_START_TEMP_LOC: fan_start_temp_d[1] = wbyte;
                IDX_FAN_START_TEMP_R2: fan_start_temp_d[2] = wbyte;
                IDX_STATUS: begin
                    lowf_d = (lowf_q & ~wbyte[ST_LOW_LSB +: NCH])
                        | lowf_set;
                    highf_d = (highf_q & ~wbyte[ST_HIGH_LSB +: NCH])
                        | highf_set;
                end
                default: ;
            endcase
        end
        if (wb_hit && !wb_we_i) begin
            unique case (idx)
                IDX_OP_R1: dat_d = op_q[0];
                IDX_OP_LOC: dat_d = op_q[1];
                IDX_OP_R2: dat_d = op_q[2];
                IDX_CAL1: dat_d = cal1_q;
                IDX_CAL2: dat_d = cal2_q;
                IDX_LOW_R1: dat_d = low_q[0];
                IDX_HIGH_R1: dat_d = high_q[0];
                IDX_LOW_LOC: dat_d = low_q[1];
                IDX_HIGH_LOC: dat_d = high_q[1];
                IDX_LOW_R2: dat_d = low_q[2];
                IDX_HIGH_R2: dat_d = high_q[2];
                IDX_ACOU: dat_d = acou_q;
                IDX_OTL_R1: dat_d = otl_q[0];
                IDX_OTL_LOC: dat_d = otl_q[1];
                IDX_OTL_R2: dat_d = otl_q[2];
                IDX_HYS_A: dat_d = hys_a_q;
                IDX_HYS_B: dat_d = {hys_b_q, 4'h0};
                IDX_FAN_START_TEMP_R1: dat_d = fan_start_temp_q[0];
                IDX_FAN_START_TEMP_LOC: dat_d = fan_start_temp_q[1];
                IDX_FAN_START_TEMP_R2: dat_d = fan_start_temp_q[2];
                IDX_STATUS: dat_d = {1'b0, |over_q, highf_q, lowf_q};
                default: dat_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_q <= {NCH{OP_RST}};
            low_q <= {NCH{LOW_RST}};
            high_q <= {NCH{HIGH_RST}};
            otl_q <= {NCH{OTL_RST}};
            hys_a_q <= {HYS_RST, HYS_RST};
            hys_b_q <= HYS_RST;
            cal1_q <= CAL_RST;
            cal2_q <= CAL_RST;
            acou_q <= ACOU_RST;
            fan_start_temp_q <= {NCH{FAN_START_TEMP_RST}};
            lowf_q <= '0;
            highf_q <= '0;
            ack_q <= 1'b0;
            dat_q <= 8'h00;
        end else begin
            op_q <= op_d;
            low_q <= low_d;
            high_q <= high_d;
            otl_q <= otl_d;
            hys_a_q <= hys_a_d;
            hys_b_q <= hys_b_d;
            cal1_q <= cal1_d;
            cal2_q <= cal2_d;
            acou_q <= acou_d;
            fan_start_temp_q <= fan_start_temp_d;
            lowf_q <= lowf_d;
            highf_q <= highf_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, dat_q};
    assign fan_start_temp = fan_start_temp_q;

    ////////////////////////////////////////////////////////////////////
    // Per-channel configuration view
    dftc_cfg_s [NCH-1:0] cfg;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cfg[c].op = op_q[c];
            cfg[c].low = low_q[c];
            cfg[c].high = high_q[c];
            cfg[c].otl = otl_q[c];
        end
        cfg[0].hyst = hys_a_q[7:4];
        cfg[1].hyst = hys_a_q[3:0];
        cfg[2].hyst = hys_b_q;
        cfg[0].code = cal2_q[CAL2_R1_LSB +: 3];
        cfg[1].code = cal2_q[CAL2_LOC_LSB +: 3];
        cfg[2].code = {cal1_q[CAL1_R2_MSB_BIT], cal2_q[CAL2_R2_LSB +: 2]};
        cfg[0].keep = acou_q[ACOU_KEEP1_BIT];
        cfg[1].keep = acou_q[ACOU_KEEP2_BIT];
        cfg[2].keep = acou_q[ACOU_KEEP3_BIT];
        cfg[0].dyn = cal1_q[CAL1_DYN_R1_BIT];
        cfg[1].dyn = cal1_q[CAL1_DYN_LOC_BIT];
        cfg[2].dyn = cal1_q[CAL1_DYN_R2_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Thermal state, scheduler and start temperature adjustment
    logic [NCH-1:0] run_q, run_d;
    logic [NCH-1:0][11:0] cnt_q, cnt_d;
    logic [NCH-1:0][7:0] prev_q, prev_d;
    dftc_drive_e [NCH-1:0] drv_q, drv_d;
    logic otp_n_q, otp_n_d;

    always_comb begin
        logic [7:0] t;
        logic [8:0] t_hy;
        logic [11:0] s_len, l_len, nxt;
        logic s_ev, l_ev, dec_s, dec_l, inc_l;
        t = 8'h00;
        t_hy = 9'h000;
        s_len = 12'h000;
        l_len = 12'h000;
        nxt = 12'h000;
        s_ev = 1'b0;
        l_ev = 1'b0;
        dec_s = 1'b0;
        dec_l = 1'b0;
        inc_l = 1'b0;
        over_d = over_q;
        run_d = run_q;
        cnt_d = cnt_q;
        prev_d = prev_q;
        fan_start_temp_hw = fan_start_temp_q;
        lowf_set = '0;
        highf_set = '0;
        for (int c = 0; c < NCH; c++) begin
            t = temp_i[c];
            // Sum form avoids underflow of limit minus hysteresis
            t_hy = {1'b0, t} + {5'h00, cfg[c].hyst};
            s_len = SHORT_BASE << cfg[c].code;
            l_len = s_len << 1;
            nxt = cnt_q[c] + 12'h001;
            s_ev = mon_tick_i && (nxt == s_len || nxt >= l_len);
            l_ev = mon_tick_i && nxt >= l_len;
            if (mon_tick_i) begin
                cnt_d[c] = l_ev ? 12'h000 : nxt;
                if (t > cfg[c].otl) begin
                    over_d[c] = 1'b1;
                end else if (t_hy < {1'b0, cfg[c].otl}) begin
                    over_d[c] = 1'b0;
                end
                if (cfg[c].keep) begin
                    run_d[c] = t > fan_start_temp_q[c];
                end else if (t > fan_start_temp_q[c]) begin
                    run_d[c] = 1'b1;
                end else if (t_hy < {1'b0, fan_start_temp_q[c]}) begin
                    run_d[c] = 1'b0;
                end
                lowf_set[c] = t < cfg[c].low;
                highf_set[c] = t > cfg[c].high;
            end
            // Dynamic control is off while the zone is at or below start temp
            if (cfg[c].dyn && t > fan_start_temp_q[c]) begin
                dec_s = s_ev && ((t_hy > {1'b0, cfg[c].op} && t > prev_q[c])
                    || t > cfg[c].high);
                dec_l = l_ev && t > cfg[c].op;
                inc_l = l_ev && t < cfg[c].low && fan_start_temp_q[c] < cfg[c].high
                    && fan_start_temp_q[c] < cfg[c].op && !dec_s && !dec_l;
            end else begin
                dec_s = 1'b0;
                dec_l = 1'b0;
                inc_l = 1'b0;
            end
            // Outside these cases the start temperature holds
            if (dec_s && dec_l) begin
                fan_start_temp_hw[c] = (fan_start_temp_q[c] > 8'h01) ? fan_start_temp_q[c] - 8'h02 : 8'h00;
            end else if (dec_s || dec_l) begin
                fan_start_temp_hw[c] = (fan_start_temp_q[c] != 8'h00) ? fan_start_temp_q[c] - 8'h01
                    : 8'h00;
            end else if (inc_l) begin
                fan_start_temp_hw[c] = fan_start_temp_q[c] + 8'h01;
            end
            if (s_ev) begin
                prev_d[c] = t;
            end
        end
        otp_n_d = ~(|over_d);
        for (int c = 0; c < NCH; c++) begin
            if (|over_d) begin
                drv_d[c] = DFTC_FULL;
            end else if (run_d[c]) begin
                drv_d[c] = DFTC_AUTO;
            end else if (cfg[c].keep) begin
                drv_d[c] = DFTC_MIN;
            end else begin
                drv_d[c] = DFTC_OFF;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            over_q <= '0;
            run_q <= '0;
            cnt_q <= '0;
            prev_q <= '0;
            drv_q <= '{default: DFTC_OFF};
            otp_n_q <= 1'b1;
        end else begin
            over_q <= over_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
            prev_q <= prev_d;
            drv_q <= drv_d;
            otp_n_q <= otp_n_d;
        end
    end

    assign fan_drive_1 = drv_q[0];
    assign fan_drive_2 = drv_q[1];
    assign fan_drive_3 = drv_q[2];
    assign overtemp_pin_n = otp_n_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic tmin0_wr;
    assign tmin0_wr = wr_en && idx == IDX_FAN_START_TEMP_R1;

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence quiet_band_s;
        mon_tick_i && !tmin0_wr
            && ({1'b0, temp_i[0]} + {5'h00, cfg[0].hyst}) <= {1'b0, op_q[0]}
            && temp_i[0] >= low_q[0] && temp_i[0] <= high_q[0];
    endsequence

    wb_ack_time_a: assert property (wb_req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle after request");
    over_full_a: assert property (mon_tick_i && temp_i[1] > otl_q[1]
        |=> fan_drive_1 == DFTC_FULL && fan_drive_2 == DFTC_FULL
        && fan_drive_3 == DFTC_FULL && !overtemp_pin_n)
        else $error("overtemp did not force full drive");
    over_hold_a: assert property (over_q[1] && !mon_tick_i
        |=> fan_drive_2 == DFTC_FULL)
        else $error("full drive dropped between ticks");
    fan_start_temp_steady_a: assert property (quiet_band_s |=> $stable(fan_start_temp_q[0]))
        else $error("start temp moved in quiet band");
    long_wrap_a: assert property (mon_tick_i
        && cnt_q[0] == ((SHORT_BASE << cfg[0].code) << 1) - 12'h001
        |=> cnt_q[0] == 12'h000)
        else $error("long cycle counter did not wrap");
    low_flag_a: assert property (mon_tick_i && temp_i[0] < low_q[0]
        |=> lowf_q[0] [*2])
        else $error("low limit flag not held");
    high_flag_a: assert property (mon_tick_i && temp_i[1] > high_q[1]
        |=> highf_q[1])
        else $error("high limit flag not set");
    keep_min_a: assert property (mon_tick_i && acou_q[ACOU_KEEP1_BIT]
        |=> fan_drive_1 != DFTC_OFF)
        else $error("keep-spinning fan turned off");
    fan_start_temp_cap_a: assert property (mon_tick_i && !tmin0_wr
        && fan_start_temp_q[0] >= high_q[0] |=> fan_start_temp_q[0] <= $past(fan_start_temp_q[0]))
        else $error("start temp rose at high limit");

endmodule

// >>> rtl/dftc_pkg.sv
/*
 * Constants, register indices and carrier types for the dynamic fan
 * threshold control block.
 * Assumes a classic Wishbone slave with 32-bit data and word addressing
 * at four times each register index.
 */
package dftc_pkg;
    localparam int NCH = 3;
    localparam int ADR_W = 9;
    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_OP_R1 = 7'h33;
    localparam logic [6:0] IDX_OP_LOC = 7'h34;
    localparam logic [6:0] IDX_OP_R2 = 7'h35;
    localparam logic [6:0] IDX_CAL1 = 7'h36;
    localparam logic [6:0] IDX_CAL2 = 7'h37;
    localparam logic [6:0] IDX_LOW_R1 = 7'h4E;
    localparam logic [6:0] IDX_HIGH_R1 = 7'h4F;
    localparam logic [6:0] IDX_LOW_LOC = 7'h50;
    localparam logic [6:0] IDX_HIGH_LOC = 7'h51;
    localparam logic [6:0] IDX_LOW_R2 = 7'h52;
    localparam logic [6:0] IDX_HIGH_R2 = 7'h53;
    localparam logic [6:0] IDX_ACOU = 7'h62;
    localparam logic [6:0] IDX_OTL_R1 = 7'h6A;
    localparam logic [6:0] IDX_OTL_LOC = 7'h6B;
    localparam logic [6:0] IDX_OTL_R2 = 7'h6C;
    localparam logic [6:0] IDX_HYS_A = 7'h6D;
    localparam logic [6:0] IDX_HYS_B = 7'h6E;
    localparam logic [6:0] IDX_FAN_START_TEMP_R1 = 7'h70;
    localparam logic [6:0] IDX_FAN_START_TEMP_LOC = 7'h71;
    localparam logic [6:0] IDX_FAN_START_TEMP_R2 = 7'h72;
    localparam logic [6:0] IDX_STATUS = 7'h73;
    // Reset values
    localparam logic [7:0] OTL_RST = 8'hA4;
    localparam logic [7:0] OP_RST = 8'hA4;
    localparam logic [7:0] LOW_RST = 8'h01;
    localparam logic [7:0] HIGH_RST = 8'h7F;
    localparam logic [3:0] HYS_RST = 4'h4;
    localparam logic [7:0] CAL_RST = 8'h00;
    localparam logic [7:0] ACOU_RST = 8'h00;
    localparam logic [7:0] FAN_START_TEMP_RST = 8'h5A;
    // Field positions
    localparam int CAL2_R1_LSB = 0;
    localparam int CAL2_LOC_LSB = 3;
    localparam int CAL2_R2_LSB = 6;
    localparam int CAL1_R2_MSB_BIT = 0;
    localparam int CAL1_DYN_R2_BIT = 5;
    localparam int CAL1_DYN_LOC_BIT = 6;
    localparam int CAL1_DYN_R1_BIT = 7;
    localparam int ACOU_KEEP1_BIT = 5;
    localparam int ACOU_KEEP2_BIT = 6;
    localparam int ACOU_KEEP3_BIT = 7;
    localparam int ST_LOW_LSB = 0;
    localparam int ST_HIGH_LSB = 3;
    localparam int ST_OVER_BIT = 6;
    // Short cycle length at code 000, in monitoring cycles
    localparam logic [11:0] SHORT_BASE = 12'h008;

    typedef enum logic [1:0] {
        DFTC_OFF = 2'b00,
        DFTC_MIN = 2'b01,
        DFTC_AUTO = 2'b10,
        DFTC_FULL = 2'b11
    } dftc_drive_e;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] otl;
        logic [3:0] hyst;
        logic [2:0] code;
        logic keep;
        logic dyn;
    } dftc_cfg_s;
endpackage

// >>> tb/dftc_core_tb.sv
/*
 * Self-checking bench for dftc_core: register reset values and readback,
 * start temperature scheduling, fan on/off hysteresis, keep-spinning
 * outputs and the overtemperature full-drive condition.
 * Assumes the package and the core under rtl/ are compiled first.
 */
`timescale 1ns/100ps
module dftc_core_tb
    import dftc_pkg::*;
;
    logic clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mon_tick_i;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [NCH-1:0][7:0] temp_i, fan_start_temp;
    dftc_drive_e fan_drive_1, fan_drive_2, fan_drive_3;
    logic overtemp_pin_n;
    int fail_count = 0;
    int n_compared = 0;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    dftc_core uut (
        .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mon_tick_i(mon_tick_i), .temp_i(temp_i),
        .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2),
        .fan_drive_3(fan_drive_3), .overtemp_pin_n(overtemp_pin_n),
        .fan_start_temp(fan_start_temp)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_drv(string name, dftc_drive_e exp, dftc_drive_e got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Classic single cycle; the wait is bounded so a dead slave ends the run
    task automatic wb_xfer(logic [6:0] idx, logic we, logic [3:0] sel,
                           logic [7:0] wd, output logic [31:0] rd);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            fail_count++;
            conclude();
        end
    endtask

    task automatic wr(logic [6:0] idx, logic [7:0] d);
        logic [31:0] r;
        wb_xfer(idx, 1'b1, 4'hF, d, r);
    endtask

    task automatic chk_reg(logic [6:0] idx, logic [7:0] exp);
        logic [31:0] r;
        wb_xfer(idx, 1'b0, 4'hF, 8'h00, r);
        chk_val($sformatf("reg %h", idx), {24'h000000, exp}, r);
    endtask

    // Back-to-back monitoring ticks, all with the same temperatures
    task automatic ticks(int n, logic [7:0] a, logic [7:0] b, logic [7:0] c);
        mon_tick_i <= 1'b1;
        temp_i <= {c, b, a};
        repeat (n) @(posedge clk);
        mon_tick_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk_st(logic [7:0] a, logic [7:0] b, logic [7:0] c);
        chk_val("start r1", {24'h000000, a}, {24'h000000, fan_start_temp[0]});
        chk_val("start loc", {24'h000000, b}, {24'h000000, fan_start_temp[1]});
        chk_val("start r2", {24'h000000, c}, {24'h000000, fan_start_temp[2]});
    endtask

    task automatic drv3(dftc_drive_e a, dftc_drive_e b, dftc_drive_e c);
        chk_drv("fan 1", a, fan_drive_1);
        chk_drv("fan 2", b, fan_drive_2);
        chk_drv("fan 3", c, fan_drive_3);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        resetn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_adr_i = '0;
        wb_dat_i = 32'h00000000;
        mon_tick_i = 1'b0;
        temp_i = '0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        drv3(DFTC_OFF, DFTC_OFF, DFTC_OFF);
        chk_val("pin", 32'h00000001, {31'h0, overtemp_pin_n});
        for (int i = 0; i < 3; i++) begin
            chk_reg(7'(IDX_OP_R1 + i), 8'hA4);
            chk_reg(7'(IDX_OTL_R1 + i), 8'hA4);
            chk_reg(7'(IDX_LOW_R1 + 2 * i), 8'h01);
            chk_reg(7'(IDX_HIGH_R1 + 2 * i), 8'h7F);
            chk_reg(7'(IDX_FAN_START_TEMP_R1 + i), FAN_START_TEMP_RST);
        end
        chk_reg(IDX_HYS_A, 8'h44);
        chk_reg(IDX_HYS_B, 8'h40);
        chk_reg(IDX_CAL1, 8'h00);
        chk_reg(IDX_CAL2, 8'h00);
        chk_reg(IDX_ACOU, 8'h00);
        // Unmapped place and a write with the low lane disabled
        wr(7'h00, 8'hFF);
        chk_reg(7'h00, 8'h00);
        wb_xfer(IDX_OP_LOC, 1'b1, 4'hE, 8'h11, r);
        chk_reg(IDX_OP_LOC, 8'hA4);
        wr(IDX_HYS_B, 8'h4F);
        chk_reg(IDX_HYS_B, 8'h40);
        // Remote 1 code 000, remote 2 code 001, all channels dynamic
        wr(IDX_OP_R1, 8'h50);
        wr(IDX_OP_R2, 8'h50);
        wr(IDX_CAL2, 8'h40);
        wr(IDX_CAL1, 8'hE0);
        chk_reg(IDX_OP_R1, 8'h50);
        chk_reg(IDX_CAL2, 8'h40);
        ticks(7, 8'h60, 8'h5C, 8'h60);
        chk_st(8'h5A, 8'h5A, 8'h5A);
        ticks(1, 8'h60, 8'h5C, 8'h60);
        chk_st(8'h59, 8'h5A, 8'h5A);
        ticks(8, 8'h60, 8'h5C, 8'h60);
        chk_st(8'h58, 8'h5A, 8'h59);
        // Remote 1 below its low limit: long cycle raises start by one
        wr(IDX_CAL1, 8'hC0);
        wr(IDX_OP_R1, 8'h70);
        wr(IDX_LOW_R1, 8'h70);
        ticks(16, 8'h5C, 8'h5C, 8'h5C);
        chk_st(8'h59, 8'h5A, 8'h59);
        chk_reg(IDX_STATUS, 8'h01);
        // Fan 3 on/off around start 0x59 with margin 4
        ticks(1, 8'h5C, 8'h5C, 8'h5A);
        chk_drv("fan 3", DFTC_AUTO, fan_drive_3);
        ticks(1, 8'h5C, 8'h5C, 8'h56);
        chk_drv("fan 3", DFTC_AUTO, fan_drive_3);
        ticks(1, 8'h5C, 8'h5C, 8'h54);
        chk_drv("fan 3", DFTC_OFF, fan_drive_3);
        wr(IDX_ACOU, 8'h80);
        ticks(1, 8'h5C, 8'h5C, 8'h54);
        chk_drv("fan 3", DFTC_MIN, fan_drive_3);
        ticks(1, 8'h5C, 8'h5C, 8'h5A);
        chk_drv("fan 3", DFTC_AUTO, fan_drive_3);
        ticks(1, 8'h5C, 8'h5C, 8'h58);
        chk_drv("fan 3", DFTC_MIN, fan_drive_3);
        wr(IDX_ACOU, 8'h60);
        ticks(1, 8'h10, 8'h10, 8'h10);
        drv3(DFTC_MIN, DFTC_MIN, DFTC_OFF);
        // Overtemp on local with a margin of 2
        wr(IDX_HYS_A, 8'h42);
        chk_reg(IDX_HYS_A, 8'h42);
        ticks(1, 8'h10, 8'hA5, 8'h10);
        drv3(DFTC_FULL, DFTC_FULL, DFTC_FULL);
        chk_val("pin", 32'h00000000, {31'h0, overtemp_pin_n});
        chk_reg(IDX_STATUS, 8'h51);
        ticks(1, 8'h10, 8'hA2, 8'h10);
        drv3(DFTC_FULL, DFTC_FULL, DFTC_FULL);
        ticks(1, 8'h10, 8'hA1, 8'h10);
        drv3(DFTC_MIN, DFTC_AUTO, DFTC_OFF);
        chk_val("pin", 32'h00000001, {31'h0, overtemp_pin_n});
        wr(IDX_STATUS, 8'h3F);
        chk_reg(IDX_STATUS, 8'h00);
        // Remote 2 code 101: its MSB sits in calibration register 1 bit 0
        wr(IDX_CAL1, 8'h21);
        chk_reg(IDX_CAL1, 8'h21);
        ticks(245, 8'h10, 8'h10, 8'h60);
        chk_st(8'h59, 8'h59, 8'h59);
        ticks(1, 8'h10, 8'h10, 8'h60);
        chk_st(8'h59, 8'h59, 8'h58);
        conclude();
    end
endmodule
